// ===== shared/ltc_pkg.sv
// constants for the transceiver host control port
// assumes straps arrive as two-bit level codes from a three-level pin sensor
package ltc_pkg;
  // three-level strap codes
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;

  // serial word layout, one byte each, lsb first
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 6;
  localparam int RW_BIT = 0;
  localparam int SEL_LSB = 1;
  localparam int SEL_MSB = 6;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // register indices on register_select_bits
  localparam logic [5:0] ADDR_PERF_STATUS = 6'h08;
  localparam logic [5:0] ADDR_TRANSITION = 6'h09;
  localparam logic [5:0] ADDR_IRQ_CLEAR = 6'h0a;
  localparam logic [5:0] ADDR_CONTROL_ONE = 6'h10;
  localparam logic [5:0] ADDR_DIAG_CTRL = 6'h11;

  // field positions
  localparam int PERF_W = 6;
  localparam int BIT_ES_OVER = 6;
  localparam int BIT_ES_UNDER = 7;
  localparam int CR1_UNIPOLAR = 4;
  localparam int CR1_ZERO_SUB = 5;
  localparam int DIAG_W = 4;
  localparam int DIAG_INS_BPV = 4;
  localparam int DIAG_INS_LER = 5;

  // reset values
  localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
  localparam logic [7:0] DIAG_CTRL_RST = 8'h00;
  localparam logic [7:0] IRQ_CLEAR_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    LTC_IDLE = 2'b00,
    LTC_CMD = 2'b01,
    LTC_DATA = 2'b10,
    LTC_DONE = 2'b11
  } ltc_state_e;
endpackage

// ===== logic/ltc_ctrl.sv
// host control port, strap decode and latched interrupt of the line transceiver
// assumes receive path and status sources run on sys_clk; straps, serial pins
// and the recovered line clock come from outside and are synchronised here
module ltc_ctrl (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [1:0] mode_strap_i,
  input wire logic [1:0] output_float_strap_i,
  input wire logic edge_select_strap_i,
  input wire logic sclk_i,
  input wire logic sel_n_i,
  input wire logic sdi_i,
  output logic serial_out_line_o,
  output logic serial_out_oe_o,
  input wire logic rclk_i,
  input wire logic rx_pos_i,
  input wire logic rx_neg_i,
  input wire logic rx_data_i,
  input wire logic rx_bpv_i,
  output logic recv_pos_rail_o,
  output logic recv_neg_rail_o,
  output logic recv_data_o,
  output logic bipolar_violation_o,
  input wire logic bipolar_violation_pin_i,
  input wire logic logic_error_insert_pin_i,
  input wire logic [ltc_pkg::DIAG_W-1:0] diag_pins_i,
  input wire logic [ltc_pkg::PERF_W-1:0] perf_status_i,
  input wire logic es_overflow_evt_i,
  input wire logic es_underflow_evt_i,
  output logic irq_n_o,
  output logic irq_n_oe_o,
  output logic host_mode_o,
  output logic outputs_float_o,
  output logic unipolar_o,
  output logic ami_code_o,
  output logic zero_sub_code_o,
  output logic [ltc_pkg::DIAG_W-1:0] diag_sel_o,
  output logic bpv_insert_o,
  output logic ler_insert_o
);
  import ltc_pkg::*;

  function automatic logic [ADDR_W-1:0] reg_select(input logic [BYTE_W-1:0] cmd);
    reg_select = cmd[SEL_MSB:SEL_LSB];
  endfunction

  // two-flop synchronisers; stage one feeds only stage two
  logic [1:0] mode_s1, mode_s2, float_s1, float_s2;
  logic edge_s1, edge_s2;
  logic [DIAG_W-1:0] diag_s1, diag_s2;
  logic bpvp_s1, bpvp_s2, lerp_s1, lerp_s2;
  logic sclk_s1, sclk_s2, sclk_d, sel_s1, sel_s2, sdi_s1, sdi_s2;
  logic rclk_s1, rclk_s2, rclk_d;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_s1 <= STRAP_LOW;
      mode_s2 <= STRAP_LOW;
      float_s1 <= STRAP_LOW;
      float_s2 <= STRAP_LOW;
      edge_s1 <= 1'b0;
      edge_s2 <= 1'b0;
      diag_s1 <= '0;
      diag_s2 <= '0;
      bpvp_s1 <= 1'b0;
      bpvp_s2 <= 1'b0;
      lerp_s1 <= 1'b0;
      lerp_s2 <= 1'b0;
    end else begin
      mode_s1 <= mode_strap_i;
      mode_s2 <= mode_s1;
      float_s1 <= output_float_strap_i;
      float_s2 <= float_s1;
      edge_s1 <= edge_select_strap_i;
      edge_s2 <= edge_s1;
      diag_s1 <= diag_pins_i;
      diag_s2 <= diag_s1;
      bpvp_s1 <= bipolar_violation_pin_i;
      bpvp_s2 <= bpvp_s1;
      lerp_s1 <= logic_error_insert_pin_i;
      lerp_s2 <= lerp_s1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d <= 1'b0;
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      rclk_s1 <= 1'b0;
      rclk_s2 <= 1'b0;
      rclk_d <= 1'b0;
    end else begin
      sclk_s1 <= sclk_i;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      sel_s1 <= sel_n_i;
      sel_s2 <= sel_s1;
      sdi_s1 <= sdi_i;
      sdi_s2 <= sdi_s1;
      rclk_s1 <= rclk_i;
      rclk_s2 <= rclk_s1;
      rclk_d <= rclk_s2;
    end
  end

  logic host, float_all, edge_hi;
  assign host = (mode_s2 == STRAP_HIGH);
  assign float_all = (float_s2 == STRAP_HIGH);
  assign edge_hi = host & edge_s2;

  logic sclk_rise, sclk_fall, rclk_rise, rclk_fall, out_edge, rx_edge;
  assign sclk_rise = sclk_s2 & ~sclk_d;
  assign sclk_fall = ~sclk_s2 & sclk_d;
  assign rclk_rise = rclk_s2 & ~rclk_d;
  assign rclk_fall = ~rclk_s2 & rclk_d;
  assign out_edge = edge_hi ? sclk_rise : sclk_fall;
  assign rx_edge = edge_hi ? rclk_fall : rclk_rise;

  // serial word engine
  ltc_state_e state;
  logic [2:0] bit_cnt;
  logic [BYTE_W-1:0] cmd_sr, wr_sr, rd_sr;
  logic cmd_done, wr_done, rd_load, wr_fire, in_read;
  logic [BYTE_W-1:0] cmd_full;
  assign cmd_full = {sdi_s2, cmd_sr[BYTE_W-1:1]};
  assign cmd_done = (state == LTC_CMD) & sclk_rise & (bit_cnt == LAST_BIT);
  assign rd_load = cmd_done & cmd_full[RW_BIT] & host;
  assign wr_done = (state == LTC_DATA) & sclk_rise & (bit_cnt == LAST_BIT);
  assign wr_fire = wr_done & ~cmd_sr[RW_BIT] & host;
  // read drive holds past the last bit until select is released
  assign in_read = ((state == LTC_DATA) | (state == LTC_DONE)) & cmd_sr[RW_BIT];

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= LTC_IDLE;
      bit_cnt <= '0;
      cmd_sr <= BYTE_ZERO;
      wr_sr <= BYTE_ZERO;
    end else if (sel_s2) begin
      state <= LTC_IDLE;
      bit_cnt <= '0;
    end else begin
      case (state)
        LTC_IDLE: begin
          state <= LTC_CMD;
          bit_cnt <= '0;
        end
        LTC_CMD: begin
          if (sclk_rise) begin
            cmd_sr <= cmd_full;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == LAST_BIT) begin
              state <= LTC_DATA;
            end
          end
        end
        LTC_DATA: begin
          if (sclk_rise) begin
            wr_sr <= {sdi_s2, wr_sr[BYTE_W-1:1]};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == LAST_BIT) begin
              state <= LTC_DONE;
            end
          end
        end
        // word complete: further clocks are ignored until select is released
        LTC_DONE: state <= LTC_DONE;
        default: state <= LTC_IDLE;
      endcase
    end
  end

  // registers
  logic [7:0] ctrl_one, diag_ctrl, irq_clear, transition_status_reg, pend;
  logic [PERF_W-1:0] perf_prev;
  logic [7:0] evt, wdata, rd_mux, tsr_clr, pend_clr;
  logic [ADDR_W-1:0] wsel;
  assign wdata = {sdi_s2, wr_sr[BYTE_W-1:1]};
  assign wsel = reg_select(cmd_sr);

  always_comb begin
    rd_mux = BYTE_ZERO;
    case (reg_select(cmd_full))
      ADDR_PERF_STATUS: rd_mux = {{(8-PERF_W){1'b0}}, perf_status_i};
      ADDR_TRANSITION: rd_mux = transition_status_reg;
      ADDR_IRQ_CLEAR: rd_mux = irq_clear;
      ADDR_CONTROL_ONE: rd_mux = ctrl_one;
      ADDR_DIAG_CTRL: rd_mux = diag_ctrl;
      default: rd_mux = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_one <= CONTROL_ONE_RST;
      diag_ctrl <= DIAG_CTRL_RST;
      irq_clear <= IRQ_CLEAR_RST;
    end else if (wr_fire) begin
      case (wsel)
        ADDR_CONTROL_ONE: ctrl_one <= wdata;
        ADDR_DIAG_CTRL: diag_ctrl <= wdata;
        ADDR_IRQ_CLEAR: irq_clear <= wdata;
        default: ;
      endcase
    end
  end

  // events: transitions of perf status and elastic store flags
  always_comb begin
    evt = BYTE_ZERO;
    evt[PERF_W-1:0] = perf_status_i ^ perf_prev;
    evt[BIT_ES_OVER] = es_overflow_evt_i;
    evt[BIT_ES_UNDER] = es_underflow_evt_i;
  end

  assign tsr_clr = (rd_load && reg_select(cmd_full) == ADDR_TRANSITION) ? 8'hff : BYTE_ZERO;
  // cleared only where the transition status bit has already been read clear
  assign pend_clr = (wr_fire && wsel == ADDR_IRQ_CLEAR) ? (wdata & ~transition_status_reg) : BYTE_ZERO;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      perf_prev <= '0;
      transition_status_reg <= BYTE_ZERO;
      pend <= BYTE_ZERO;
    end else begin
      perf_prev <= perf_status_i;
      // set wins over a read-clear in the same cycle
      transition_status_reg <= (transition_status_reg & ~tsr_clr) | evt;
      pend <= (pend & ~pend_clr) | (evt & ~irq_clear);
    end
  end

  // serial read data
  logic out_armed;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_sr <= BYTE_ZERO;
      out_armed <= 1'b0;
      serial_out_line_o <= 1'b0;
    end else if (rd_load) begin
      rd_sr <= rd_mux;
      out_armed <= 1'b1;
    end else if (!in_read) begin
      out_armed <= 1'b0;
    end else if (out_edge && out_armed) begin
      serial_out_line_o <= rd_sr[0];
      rd_sr <= {1'b0, rd_sr[BYTE_W-1:1]};
    end
  end
  assign serial_out_oe_o = in_read & host & ~float_all;

  // receive outputs on the selected recovered clock edge
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      recv_pos_rail_o <= 1'b0;
      recv_neg_rail_o <= 1'b0;
      recv_data_o <= 1'b0;
      bipolar_violation_o <= 1'b0;
    end else if (rx_edge) begin
      recv_pos_rail_o <= rx_pos_i;
      recv_neg_rail_o <= rx_neg_i;
      recv_data_o <= rx_data_i;
      bipolar_violation_o <= rx_bpv_i;
    end
  end

  // open-drain: value fixed low, only the enable moves
  assign irq_n_o = 1'b0;
  assign irq_n_oe_o = host & (|pend) & ~float_all;

  // option decode
  logic uni_hw, zs_hw;
  assign uni_hw = (mode_s2 == STRAP_OPEN) | (float_s2 == STRAP_OPEN);
  assign zs_hw = (mode_s2 == STRAP_OPEN);
  assign host_mode_o = host;
  assign outputs_float_o = float_all;
  assign unipolar_o = host ? ctrl_one[CR1_UNIPOLAR] : uni_hw;
  assign zero_sub_code_o = host ? ctrl_one[CR1_ZERO_SUB] : zs_hw;
  assign ami_code_o = unipolar_o & ~zero_sub_code_o;
  assign diag_sel_o = host ? diag_ctrl[DIAG_W-1:0] : diag_s2;
  // pins win whenever the data path is unipolar, register only in host bipolar
  assign bpv_insert_o = (host & ~unipolar_o) ? diag_ctrl[DIAG_INS_BPV] : bpvp_s2;
  assign ler_insert_o = (host & ~unipolar_o) ? diag_ctrl[DIAG_INS_LER] : lerp_s2;
endmodule

// ===== bench/ltc_ctrl_assertions.sv
// pin-level assertions for the host control port
// bound to ltc_ctrl; straps only move away from receive and serial edges
module ltc_ctrl_chk (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [1:0] mode_strap_i,
  input wire logic [1:0] output_float_strap_i,
  input wire logic edge_select_strap_i,
  input wire logic sclk_i,
  input wire logic rclk_i,
  input wire logic bipolar_violation_pin_i,
  input wire logic serial_out_line_o,
  input wire logic serial_out_oe_o,
  input wire logic recv_pos_rail_o,
  input wire logic recv_neg_rail_o,
  input wire logic recv_data_o,
  input wire logic bipolar_violation_o,
  input wire logic irq_n_o,
  input wire logic irq_n_oe_o,
  input wire logic host_mode_o,
  input wire logic outputs_float_o,
  input wire logic unipolar_o,
  input wire logic ami_code_o,
  input wire logic zero_sub_code_o,
  input wire logic bpv_insert_o
);
  import ltc_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // four samples cover the two strap sync flops
  AST_MODE_HOST: assert property ((mode_strap_i == STRAP_HIGH)[*4] |-> host_mode_o)
    else $error("host mode not selected");
  AST_MODE_PIN: assert property ((mode_strap_i != STRAP_HIGH)[*4] |->
    !host_mode_o && !serial_out_oe_o && !irq_n_oe_o)
    else $error("pin mode not selected");
  AST_FLOAT: assert property ((output_float_strap_i == STRAP_HIGH)[*4] |->
    outputs_float_o && !irq_n_oe_o && !serial_out_oe_o)
    else $error("outputs not floated");
  AST_ZERO_SUB: assert property ((mode_strap_i == STRAP_OPEN)[*4] |->
    unipolar_o && zero_sub_code_o && !ami_code_o)
    else $error("open mode coding wrong");
  AST_BIPOLAR: assert property (
    (mode_strap_i == STRAP_LOW && output_float_strap_i != STRAP_OPEN)[*4] |->
    !unipolar_o && !ami_code_o && !zero_sub_code_o)
    else $error("bipolar option wrong");
  AST_IRQ_SINK: assert property (irq_n_o == 1'b0)
    else $error("interrupt pin drives high");
  // rclk halves last eight cycles, so two back shows the phase of the edge used
  AST_RX_EDGE: assert property (
    $changed({recv_pos_rail_o, recv_neg_rail_o, recv_data_o, bipolar_violation_o}) |->
    $past(rclk_i, 2) != (host_mode_o && edge_select_strap_i))
    else $error("receive output on wrong edge");
  AST_SDO_EDGE: assert property ($changed(serial_out_line_o) |->
    $past(sclk_i, 2) == (host_mode_o && edge_select_strap_i))
    else $error("serial output on wrong edge");
  AST_BPV_PIN: assert property (
    (host_mode_o && unipolar_o && bipolar_violation_pin_i)[*4] |-> bpv_insert_o)
    else $error("violation insert not from pin");
endmodule

// ===== bench/ltc_host_model.sv
// host processor side of the serial control port
// one word per call, sclk idle low between words
module ltc_host_model (
  output logic sclk_o,
  output logic sel_n_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic out_rise_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // command byte then data byte, lsb first
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] w;
    w = {wd, cmd};
    rd = 8'h00;
    sel_n_o = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sdi_o = w[i];
      #80 sclk_o = 1'b1;
      if (i > 7 && !out_rise_i) rd[i-8] = sdo_i;
      #80 sclk_o = 1'b0;
      if (i > 7 && out_rise_i) rd[i-8] = sdo_i;
    end
    #80 sel_n_o = 1'b1;
    // released data line shows no stale bit
    sdi_o = ~w[15];
    #80;
  endtask
endmodule

// ===== bench/line_transceiver_host_control_port_tb.sv
// self-checking bench for the host control port
// host model drives serial words, bench drives straps and status events
module line_transceiver_host_control_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ltc_pkg::*;
  logic sys_clk, arst_n, edge_s, rclk, rx, bpv_pin, ler_pin, ovf, unf;
  logic [1:0] mode, flt;
  logic [3:0] diag;
  logic [5:0] perf;
  logic [7:0] rd;
  wire sclk, sel_n, sdi, serial_out_line, sdo_oe, irq_n, irq_oe, host, flo, uni, ami, zs, bpv_ins, ler_ins;
  wire [3:0] dsel;
  wire irq_line = irq_oe ? irq_n : 1'b1;
  int errors = 0, samples_checked = 0;
  ltc_ctrl i_dut (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .mode_strap_i(mode), .output_float_strap_i(flt),
    .edge_select_strap_i(edge_s), .sclk_i(sclk), .sel_n_i(sel_n), .sdi_i(sdi), .serial_out_line_o(serial_out_line),
    .serial_out_oe_o(sdo_oe), .rclk_i(rclk), .rx_pos_i(rx), .rx_neg_i(~rx), .rx_data_i(rx), .rx_bpv_i(rx),
    .recv_pos_rail_o(), .recv_neg_rail_o(), .recv_data_o(), .bipolar_violation_o(),
    .bipolar_violation_pin_i(bpv_pin), .logic_error_insert_pin_i(ler_pin), .diag_pins_i(diag),
    .perf_status_i(perf), .es_overflow_evt_i(ovf), .es_underflow_evt_i(unf), .irq_n_o(irq_n),
    .irq_n_oe_o(irq_oe), .host_mode_o(host), .outputs_float_o(flo), .unipolar_o(uni), .ami_code_o(ami),
    .zero_sub_code_o(zs), .diag_sel_o(dsel), .bpv_insert_o(bpv_ins), .ler_insert_o(ler_ins));
  // a released data line shows the inverse of its last bit
  ltc_host_model i_host (.sclk_o(sclk), .sel_n_o(sel_n), .sdi_o(sdi), .sdo_i(sdo_oe ? serial_out_line : ~serial_out_line),
    .out_rise_i(mode == STRAP_HIGH && edge_s));
  always #5 sys_clk = ~sys_clk;
  always #80 rclk = ~rclk;
  always @(negedge rclk) rx <= ~rx;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // straps move late in the low phase of rclk, clear of any edge in flight
  task automatic straps(input logic [1:0] m, input logic [1:0] f, input logic e);
    @(negedge rclk);
    wt(6);
    mode = m;
    flt = f;
    edge_s = e;
    wt(6);
  endtask
  // top command bit set on writes: decode must ignore it
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    i_host.xfer({1'b1, a, 1'b0}, d, rd);
    wt(2);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(negedge sys_clk);
    i_host.xfer({1'b0, a, 1'b1}, 8'h00, rd);
    check(rd & mask, exp);
  endtask
  task automatic ev(input logic o, input logic u, input logic oe_exp);
    ovf = o;
    unf = u;
    wt(1);
    ovf = 1'b0;
    unf = 1'b0;
    wt(2);
    check({6'h0, irq_oe, irq_line}, {6'h0, oe_exp, !oe_exp});
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    stop_test();
  end
  initial begin
    {sys_clk, arst_n, rclk, rx, bpv_pin, ler_pin, ovf, unf, edge_s} = 9'h000;
    {mode, flt, diag, perf} = 14'h0000;
    wt(8);
    arst_n = 1'b1;
    wt(6);
    diag = 4'ha;
    for (int m = 0; m < 3; m++) begin
      for (int f = 0; f < 3; f++) begin
        straps(m[1:0], f[1:0], m != 2);
        if (mode == STRAP_HIGH) begin
          check({6'h0, host, flo}, {6'h0, 1'b1, flt == STRAP_HIGH});
        end else begin
          check({3'h0, host, flo, uni, ami, zs},
            {3'h0, 1'b0, flt == STRAP_HIGH, mode == STRAP_OPEN || flt == STRAP_OPEN,
            mode == STRAP_LOW && flt == STRAP_OPEN, mode == STRAP_OPEN});
        end
        if (mode != STRAP_HIGH) check({4'h0, dsel}, {4'h0, diag});
      end
      if (m == 0) wr(ADDR_CONTROL_ONE, 8'h30);
    end
    $display("test straps done");
    straps(STRAP_HIGH, STRAP_OPEN, 1'b0);
    rdchk(ADDR_CONTROL_ONE, 8'hff, CONTROL_ONE_RST);
    wr(ADDR_CONTROL_ONE, 8'h30);
    check({6'h0, uni, zs}, 8'h03);
    rdchk(ADDR_CONTROL_ONE, 8'hff, 8'h30);
    straps(STRAP_HIGH, STRAP_OPEN, 1'b1);
    rdchk(ADDR_CONTROL_ONE, 8'hff, 8'h30);
    rdchk(6'h3f, 8'hff, BYTE_ZERO);
    straps(STRAP_HIGH, STRAP_OPEN, 1'b0);
    $display("test access done");
    bpv_pin = 1'b1;
    wr(ADDR_DIAG_CTRL, 8'h23);
    check({2'h0, dsel, bpv_ins, ler_ins}, {2'h0, 4'h3, 1'b1, 1'b0});
    // host ami coding, then host bipolar takes insertion from the register
    wr(ADDR_CONTROL_ONE, 8'h10);
    check({5'h0, uni, ami, zs}, 8'h06);
    wr(ADDR_CONTROL_ONE, 8'h00);
    check({4'h0, uni, ami, bpv_ins, ler_ins}, 8'h01);
    $display("test diag done");
    ev(1'b1, 1'b0, 1'b1);
    wt(20);
    check({7'h0, irq_oe}, 8'h01);
    rdchk(ADDR_TRANSITION, 8'hff, 8'h40);
    wr(ADDR_IRQ_CLEAR, 8'h40);
    check({7'h0, irq_oe}, 8'h00);
    ev(1'b1, 1'b0, 1'b0);
    wr(ADDR_IRQ_CLEAR, 8'h00);
    ev(1'b0, 1'b1, 1'b1);
    wr(ADDR_IRQ_CLEAR, 8'h80);
    check({7'h0, irq_oe}, 8'h01);
    rdchk(ADDR_TRANSITION, 8'h80, 8'h80);
    wr(ADDR_IRQ_CLEAR, 8'h80);
    check({7'h0, irq_oe}, 8'h00);
    perf = 6'h01;
    wt(3);
    check({7'h0, irq_oe}, 8'h01);
    rdchk(ADDR_PERF_STATUS, 8'hff, 8'h01);
    straps(STRAP_HIGH, STRAP_HIGH, 1'b0);
    rdchk(ADDR_PERF_STATUS, 8'h00, 8'h00);
    check({6'h0, flo, irq_oe}, 8'h02);
    $display("test interrupt done");
    stop_test();
  end
endmodule
bind ltc_ctrl ltc_ctrl_chk i_chk (.*);
